// ### verilog/logic_cell.sv
// configurable logic cell: lookup tables, chains, one flip-flop, bus emulation
`timescale 1ns/100ps
`include "logic_cell_defines.svh"

module logic_cell (
	input  wire logic                           clk,
	input  wire logic                           sys_rst,
	// configuration
	input  logic_cell_pkg::op_mode_e            op_mode,
	input  logic_cell_pkg::ctl_mode_e           ctl_mode,
	input  wire logic [`LUT4_MASK_W-1:0]        lut4_mask,
	input  wire logic [`LUT3_MASK_W-1:0]        data_lut_mask,
	input  wire logic [`LUT3_MASK_W-1:0]        carry_lut_mask,
	input  wire logic                           lut_uses_carry_in,
	input  wire logic                           cascade_enable,
	input  wire logic                           cascade_or,
	input  wire logic                           register_packed,
	input  wire logic                           local_sel_register,
	input  wire logic                           global_sel_register,
	input  wire logic                           enable_from_first_data_input,
	input  wire logic                           chip_reset_enable,
	input  wire logic                           chip_reset_presets,
	// functional inputs
	input  wire logic                           first_data_input,
	input  wire logic                           second_data_input,
	input  wire logic                           third_data_input,
	input  wire logic                           fourth_data_input,
	input  wire logic                           carry_in,
	input  wire logic                           cascade_in,
	input  wire logic                           clock_enable,
	// register controls, active low
	input  wire logic                           group_control_a_n,
	input  wire logic                           group_control_b_n,
	input  wire logic                           chip_reset_n,
	// emulated internal bus drivers
	input  wire logic [`TRI_DRIVERS-1:0]        tri_data,
	input  wire logic [`TRI_DRIVERS-1:0]        tri_enable,
	// outputs
	output logic                                local_out,
	output logic                                global_out,
	output logic                                carry_out,
	output logic                                cascade_out,
	output logic                                tri_bus_out
);

	// ----------------------------------------------------------------
	// mode decode
	// ----------------------------------------------------------------
	// modes are straps: changing them while clocked gives undefined results
	wire mode_normal = (op_mode == logic_cell_pkg::op_normal);
	wire mode_arith  = (op_mode == logic_cell_pkg::op_arith);
	wire mode_updown = (op_mode == logic_cell_pkg::op_updown);
	wire mode_clrcnt = (op_mode == logic_cell_pkg::op_clrcnt);
	wire mode_count  = mode_updown | mode_clrcnt;

	wire ctl_clr     = (ctl_mode == logic_cell_pkg::ctl_clr);
	wire ctl_pre     = (ctl_mode == logic_cell_pkg::ctl_pre);
	wire ctl_clr_pre = (ctl_mode == logic_cell_pkg::ctl_clr_pre);
	wire ctl_ld_clr  = (ctl_mode == logic_cell_pkg::ctl_ld_clr);
	wire ctl_ld_pre  = (ctl_mode == logic_cell_pkg::ctl_ld_pre);
	wire ctl_ld      = (ctl_mode == logic_cell_pkg::ctl_ld);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	// the flip-flop holds the inverted value in load-with-preset mode
	logic ff_reg;
	logic ff_next;
	wire  ff_inverted = ctl_ld_pre;
	wire  reg_q       = ff_inverted ? ~ff_reg : ff_reg;

	// ----------------------------------------------------------------
	// lookup tables
	// ----------------------------------------------------------------
	wire       lut4_in3  = lut_uses_carry_in ? carry_in : third_data_input;
	wire [3:0] lut4_sel  = {fourth_data_input, lut4_in3, second_data_input, first_data_input};
	logic      lut4_result;

	lut_n #(
		.WIDTH (`LUT4_INPUTS)
	) u_lut4 (
		.mask   (lut4_mask),
		.sel    (lut4_sel),
		.result (lut4_result)
	);

	// counters steer direction from the cascade-in position; clearable mode counts up
	wire       count_dir = mode_updown ? cascade_in : `BIT_HIGH;
	wire [2:0] arith_sel = {carry_in, second_data_input, first_data_input};
	wire [2:0] count_sel = {count_dir, carry_in, reg_q};
	wire [2:0] lut3_sel  = mode_count ? count_sel : arith_sel;
	logic      data_lut_result;
	logic      carry_lut_result;

	lut_n #(
		.WIDTH (`LUT3_INPUTS)
	) u_data_lut (
		.mask   (data_lut_mask),
		.sel    (lut3_sel),
		.result (data_lut_result)
	);

	lut_n #(
		.WIDTH (`LUT3_INPUTS)
	) u_carry_lut (
		.mask   (carry_lut_mask),
		.sel    (lut3_sel),
		.result (carry_lut_result)
	);

	// ----------------------------------------------------------------
	// cascade chain
	// ----------------------------------------------------------------
	// OR is built as AND of inverted terms, inverted again on the way out
	wire table_out    = mode_normal ? lut4_result : data_lut_result;
	wire casc_a       = cascade_or ? ~table_out : table_out;
	wire casc_b       = cascade_or ? ~cascade_in : cascade_in;
	wire casc_and     = casc_a & casc_b;
	wire casc_merged  = cascade_or ? ~casc_and : casc_and;
	// counters spend cascade-in on direction or clear, so no merge there
	wire casc_allowed = cascade_enable & (mode_normal | mode_arith);
	wire comb_result  = casc_allowed ? casc_merged : table_out;
	wire carry_next   = mode_normal ? `BIT_LOW : carry_lut_result;

	// ----------------------------------------------------------------
	// synchronous data path
	// ----------------------------------------------------------------
	wire count_enable = second_data_input;
	wire count_value  = count_enable ? data_lut_result : reg_q;
	wire sync_load    = third_data_input;
	wire load_mux     = sync_load ? fourth_data_input : count_value;
	// cascade-in acts as an active-low synchronous clear in clearable mode
	wire count_d      = mode_clrcnt ? (load_mux & cascade_in) : load_mux;
	wire normal_d     = register_packed ? fourth_data_input : comb_result;
	wire sync_d       = mode_count ? count_d : (mode_normal ? normal_d : comb_result);
	wire reg_enable   = enable_from_first_data_input ? first_data_input : clock_enable;

	// ----------------------------------------------------------------
	// clear, preset and load controls
	// ----------------------------------------------------------------
	// the controls are taken at the clock edge, not through an async flop path
	wire ctl_a = ~group_control_a_n;
	wire ctl_b = ~group_control_b_n;

	wire clr_force    = ctl_clr & (ctl_a | ctl_b);
	wire pre_force    = ctl_pre & ctl_a;
	wire cp_force     = ctl_clr_pre & (ctl_a | ctl_b);
	wire cp_value     = ctl_b ? `BIT_LOW : `BIT_HIGH;
	wire lc_force     = ctl_ld_clr & (ctl_a | ctl_b);
	wire lc_value     = ctl_b ? `BIT_LOW : third_data_input;
	wire lp_force     = ctl_ld_pre & (ctl_a | ctl_b);
	wire lp_value     = ctl_b ? `BIT_HIGH : third_data_input;
	wire ld_force     = ctl_ld & ctl_a;

	wire async_force  = clr_force | pre_force | cp_force | lc_force | lp_force | ld_force;
	wire async_value  = clr_force ? `BIT_LOW :
		pre_force ? `BIT_HIGH :
		cp_force  ? cp_value :
		lc_force  ? lc_value :
		lp_force  ? lp_value :
		third_data_input;

	wire preset_mode  = ctl_pre | ctl_clr_pre | ctl_ld_pre;
	wire chip_force   = chip_reset_enable & ~chip_reset_n;
	wire chip_value   = chip_reset_presets & preset_mode;

	// chip reset first, then the control lines, then the clock enable
	wire q_next = chip_force ? chip_value :
		async_force ? async_value :
		reg_enable  ? sync_d : reg_q;

	always_comb begin
		ff_next = ff_inverted ? ~q_next : q_next;
	end

	// ----------------------------------------------------------------
	// emulated internal bus
	// ----------------------------------------------------------------
	localparam logic [`TRI_DRIVERS-1:0] ONE_DRIVER = {{(`TRI_DRIVERS-1){1'h0}}, 1'h1};
	wire any_driver   = |tri_enable;
	wire many_drivers = |(tri_enable & (tri_enable - ONE_DRIVER));
	wire one_value    = |(tri_enable & tri_data);
	wire tri_next     = !any_driver ? `TRI_FLOAT_VALUE :
		many_drivers ? `TRI_CONTEND_VAL : one_value;

	// ----------------------------------------------------------------
	// output selection
	// ----------------------------------------------------------------
	// register selection uses the next state so the pin tracks the flop
	wire local_next  = local_sel_register ? q_next : comb_result;
	wire global_next = global_sel_register ? q_next : comb_result;

	// ----------------------------------------------------------------
	// flip-flops
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ff_reg <= `BIT_LOW;
		end else begin
			ff_reg <= ff_next;
		end
	end

	// outputs are registered, so table results appear one clock late
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			local_out   <= `BIT_LOW;
			global_out  <= `BIT_LOW;
			carry_out   <= `BIT_LOW;
			cascade_out <= `BIT_LOW;
			tri_bus_out <= `TRI_FLOAT_VALUE;
		end else begin
			local_out   <= local_next;
			global_out  <= global_next;
			carry_out   <= carry_next;
			cascade_out <= comb_result;
			tri_bus_out <= tri_next;
		end
	end

endmodule

// ### verilog/logic_cell_defines.svh
// constants for the configurable logic cell
`ifndef LOGIC_CELL_DEFINES_SVH
`define LOGIC_CELL_DEFINES_SVH

// ----------------------------------------------------------------
// operating mode codes, one-hot
// ----------------------------------------------------------------
`define OP_MODE_W        4
`define OP_NORMAL_CODE   4'h1
`define OP_ARITH_CODE    4'h2
`define OP_UPDOWN_CODE   4'h4
`define OP_CLRCNT_CODE   4'h8

// ----------------------------------------------------------------
// clear / preset control mode codes, one-hot
// ----------------------------------------------------------------
`define CTL_MODE_W       6
`define CTL_CLR_CODE     6'h01
`define CTL_PRE_CODE     6'h02
`define CTL_CLR_PRE_CODE 6'h04
`define CTL_LD_CLR_CODE  6'h08
`define CTL_LD_PRE_CODE  6'h10
`define CTL_LD_CODE      6'h20

// ----------------------------------------------------------------
// table sizes and reset values
// ----------------------------------------------------------------
`define LUT4_INPUTS      4
`define LUT3_INPUTS      3
`define LUT4_MASK_W      16
`define LUT3_MASK_W      8
`define TRI_DRIVERS      4
`define BIT_LOW          1'h0
`define BIT_HIGH         1'h1
`define TRI_FLOAT_VALUE  1'h1
`define TRI_CONTEND_VAL  1'h0

`endif

// ### verilog/logic_cell_pkg.sv
// types shared by the logic cell design files
`include "logic_cell_defines.svh"

package logic_cell_pkg;

	typedef enum logic [`OP_MODE_W-1:0] {
		op_normal = `OP_NORMAL_CODE,
		op_arith  = `OP_ARITH_CODE,
		op_updown = `OP_UPDOWN_CODE,
		op_clrcnt = `OP_CLRCNT_CODE
	} op_mode_e;

	typedef enum logic [`CTL_MODE_W-1:0] {
		ctl_clr     = `CTL_CLR_CODE,
		ctl_pre     = `CTL_PRE_CODE,
		ctl_clr_pre = `CTL_CLR_PRE_CODE,
		ctl_ld_clr  = `CTL_LD_CLR_CODE,
		ctl_ld_pre  = `CTL_LD_PRE_CODE,
		ctl_ld      = `CTL_LD_CODE
	} ctl_mode_e;

endpackage

// ### verilog/lut_n.sv
// generic lookup table: the mask bit addressed by the select inputs
`timescale 1ns/100ps

module lut_n #(
	parameter int unsigned WIDTH = 4
) (
	input  wire logic [(1<<WIDTH)-1:0] mask,
	input  wire logic [WIDTH-1:0]      sel,
	output wire logic                  result
);

	assign result = mask[sel];

endmodule

// ### verification/neighbour_model.sv
// neighbouring cell and group control lines that face the logic cell
`timescale 1ns/100ps
module neighbour_model (
	input  wire logic carry_req,
	input  wire logic cascade_req,
	input  wire logic ctl_a,
	input  wire logic ctl_b,
	output wire logic carry_in,
	output wire logic cascade_in,
	output wire logic group_control_a_n,
	output wire logic group_control_b_n
);
	// ------------------------------------------------
	// chain links and control lines
	// ------------------------------------------------
	assign carry_in          = carry_req;
	assign cascade_in        = cascade_req;
	// an idle control rests high, so unused lines never clear or preset
	assign group_control_a_n = ~ctl_a;
	assign group_control_b_n = ~ctl_b;
endmodule

// ### verification/logic_cell_monitor.sv
// concurrent checks on the logic cell ports
`timescale 1ns/100ps
`include "logic_cell_defines.svh"
module logic_cell_monitor (
	input wire logic                    clk,
	input wire logic                    sys_rst,
	input logic_cell_pkg::op_mode_e     op_mode,
	input logic_cell_pkg::ctl_mode_e    ctl_mode,
	input wire logic                    cascade_enable,
	input wire logic                    cascade_or,
	input wire logic                    register_packed,
	input wire logic                    local_sel_register,
	input wire logic                    enable_from_first_data_input,
	input wire logic                    chip_reset_enable,
	input wire logic                    chip_reset_presets,
	input wire logic                    first_data_input,
	input wire logic                    third_data_input,
	input wire logic                    fourth_data_input,
	input wire logic                    cascade_in,
	input wire logic                    clock_enable,
	input wire logic                    group_control_a_n,
	input wire logic                    group_control_b_n,
	input wire logic                    chip_reset_n,
	input wire logic [`TRI_DRIVERS-1:0] tri_enable,
	input wire logic                    local_out,
	input wire logic                    carry_out,
	input wire logic                    cascade_out,
	input wire logic                    tri_bus_out
);
	// ------------------------------------------------
	// decoded conditions
	// ------------------------------------------------
	wire ca  = ~group_control_a_n;
	wire cb  = ~group_control_b_n;
	wire cr  = chip_reset_enable & ~chip_reset_n;
	wire sr  = local_sel_register & ~cr;
	wire en  = enable_from_first_data_input ? first_data_input : clock_enable;
	wire nrm = op_mode == logic_cell_pkg::op_normal;
	wire m_c = ctl_mode == logic_cell_pkg::ctl_clr;
	wire m_p = ctl_mode == logic_cell_pkg::ctl_pre;
	wire m_cp = ctl_mode == logic_cell_pkg::ctl_clr_pre;
	wire m_lc = ctl_mode == logic_cell_pkg::ctl_ld_clr;
	wire m_lp = ctl_mode == logic_cell_pkg::ctl_ld_pre;
	wire m_l = ctl_mode == logic_cell_pkg::ctl_ld;
	wire pv  = chip_reset_presets & (m_p | m_cp | m_lp);
	default clocking cb_clk @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence idle_s; sr && !ca && !cb; endsequence
	// ------------------------------------------------
	// assertions
	// ------------------------------------------------
	tri_low_a: assert property ($countones(tri_enable) > 1 |=> !tri_bus_out)
		else $error("bus contention not resolved low");
	tri_high_a: assert property (tri_enable == 4'h0 |=> tri_bus_out)
		else $error("floating bus not resolved high");
	chip_rst_a: assert property (cr && local_sel_register |=> local_out == $past(pv))
		else $error("chip reset value wrong");
	hold_a: assert property (idle_s and !en |=> $stable(local_out))
		else $error("register moved with enable low");
	clr_line_a: assert property (sr && (ca || cb) && m_c |=> !local_out)
		else $error("clear line did not clear");
	b_wins_a: assert property (sr && cb && (m_cp || m_lc) |=> !local_out)
		else $error("second line did not clear");
	ldpre_b_a: assert property (sr && cb && m_lp |=> local_out)
		else $error("second line did not preset");
	load_a: assert property (sr && ca && !cb && (m_l || m_lc || m_lp)
		|=> local_out == $past(third_data_input))
		else $error("async load value wrong");
	pack_a: assert property (idle_s and en && nrm && register_packed
		|=> local_out == $past(fourth_data_input))
		else $error("packed register value wrong");
	carry_a: assert property (nrm |=> !carry_out)
		else $error("carry out set in normal mode");
	casc_a: assert property (nrm && cascade_enable && cascade_in == cascade_or
		|=> cascade_out == $past(cascade_or))
		else $error("cascade merge wrong");
endmodule

// ### verification/tb.sv
// self-checking bench for the logic cell
`timescale 1ns/100ps
`include "logic_cell_defines.svh"
module tb;
	logic clk = 1'h0, sys_rst = 1'h1, chip_reset_n = 1'h1;
	logic_cell_pkg::op_mode_e op_mode = logic_cell_pkg::op_normal;
	logic_cell_pkg::ctl_mode_e ctl_mode = logic_cell_pkg::ctl_clr;
	logic [15:0] lut4_mask = 16'h8000;
	logic [7:0] data_lut_mask = 8'h96, carry_lut_mask = 8'hE8;
	logic lut_uses_carry_in = 1'h0, cascade_enable = 1'h0, cascade_or = 1'h0;
	logic register_packed = 1'h1, local_sel_register = 1'h1, global_sel_register = 1'h0;
	logic enable_from_first_data_input = 1'h0, chip_reset_enable = 1'h0, chip_reset_presets = 1'h0;
	logic first_data_input = 1'h0, second_data_input = 1'h0, third_data_input = 1'h0;
	logic fourth_data_input = 1'h0, clock_enable = 1'h0, carry_req = 1'h0;
	logic cascade_req = 1'h0, ctl_a = 1'h0, ctl_b = 1'h0;
	logic [3:0] tri_data = 4'h5, tri_enable = 4'h0;
	wire carry_in, cascade_in, group_control_a_n, group_control_b_n;
	wire local_out, global_out, carry_out, cascade_out, tri_bus_out;
	int mismatches = 0, n_tests = 0, cyc = 0;
	logic [3:0] te [4] = '{4'h0, 4'h3, 4'h4, 4'h2};
	always #4 clk = ~clk;
	logic_cell dut_u (.clk, .sys_rst, .op_mode, .ctl_mode, .lut4_mask, .data_lut_mask,
		.carry_lut_mask, .lut_uses_carry_in, .cascade_enable, .cascade_or, .register_packed,
		.local_sel_register, .global_sel_register, .enable_from_first_data_input, .chip_reset_enable,
		.chip_reset_presets, .first_data_input, .second_data_input, .third_data_input,
		.fourth_data_input, .carry_in, .cascade_in, .clock_enable, .group_control_a_n,
		.group_control_b_n, .chip_reset_n, .tri_data, .tri_enable, .local_out, .global_out,
		.carry_out, .cascade_out, .tri_bus_out);
	neighbour_model nb_u (.carry_req, .cascade_req, .ctl_a, .ctl_b, .carry_in, .cascade_in,
		.group_control_a_n, .group_control_b_n);
	// ------------------------------------------------
	// access tasks
	// ------------------------------------------------
	task automatic tick(input int n = 1);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ctl(input logic_cell_pkg::ctl_mode_e m, input logic a, b, d, e);
		ctl_mode = m;
		third_data_input = d;
		ctl_a = a;
		ctl_b = b;
		tick();
		ctl_a = 1'h0;
		ctl_b = 1'h0;
		chk(local_out, e);
	endtask
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// a hang is cut short well beyond the roughly fifty cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc > 1000) begin
			mismatches++;
			complete_run();
		end
	end
	// ------------------------------------------------
	// tests
	// ------------------------------------------------
	initial begin
		tick(12);
		sys_rst = 1'h0;
		tick();
		chk(local_out, 1'h0);
		chk(tri_bus_out, 1'h1);
		fin("reset");
		fourth_data_input = 1'h1;
		clock_enable = 1'h1;
		tick();
		chk(local_out, 1'h1);
		clock_enable = 1'h0;
		fourth_data_input = 1'h0;
		tick(3);
		chk(local_out, 1'h1);
		enable_from_first_data_input = 1'h1;
		first_data_input = 1'h1;
		tick();
		chk(local_out, 1'h0);
		first_data_input = 1'h0;
		fin("pack");
		ctl(logic_cell_pkg::ctl_pre, 1'h1, 1'h0, 1'h0, 1'h1);
		ctl(logic_cell_pkg::ctl_clr, 1'h1, 1'h0, 1'h0, 1'h0);
		ctl(logic_cell_pkg::ctl_ld, 1'h1, 1'h0, 1'h1, 1'h1);
		ctl(logic_cell_pkg::ctl_clr, 1'h0, 1'h1, 1'h0, 1'h0);
		ctl(logic_cell_pkg::ctl_clr_pre, 1'h1, 1'h0, 1'h0, 1'h1);
		ctl(logic_cell_pkg::ctl_clr_pre, 1'h1, 1'h1, 1'h0, 1'h0);
		ctl(logic_cell_pkg::ctl_ld_clr, 1'h1, 1'h0, 1'h1, 1'h1);
		ctl(logic_cell_pkg::ctl_ld_clr, 1'h1, 1'h1, 1'h1, 1'h0);
		ctl(logic_cell_pkg::ctl_ld_pre, 1'h0, 1'h1, 1'h0, 1'h1);
		ctl(logic_cell_pkg::ctl_ld_pre, 1'h1, 1'h0, 1'h0, 1'h0);
		chip_reset_enable = 1'h1;
		chip_reset_presets = 1'h1;
		chip_reset_n = 1'h0;
		ctl(logic_cell_pkg::ctl_pre, 1'h0, 1'h0, 1'h0, 1'h1);
		ctl(logic_cell_pkg::ctl_ld, 1'h1, 1'h0, 1'h1, 1'h0);
		chip_reset_n = 1'h1;
		fin("controls");
		for (int i = 0; i < 4; i++) begin
			tri_enable = te[i];
			tick();
			chk(tri_bus_out, tri_data[i]);
		end
		fin("bus");
		{first_data_input, second_data_input, third_data_input, fourth_data_input} = 4'hF;
		tick();
		chk(global_out, 1'h1);
		chk(local_out, 1'h1);
		lut_uses_carry_in = 1'h1;
		tick();
		chk(global_out, 1'h0);
		chk(carry_out, 1'h0);
		carry_req = 1'h1;
		cascade_enable = 1'h1;
		tick();
		chk(cascade_out, 1'h0);
		cascade_or = 1'h1;
		tick();
		chk(cascade_out, 1'h1);
		fin("normal");
		op_mode = logic_cell_pkg::op_arith;
		cascade_or = 1'h0;
		cascade_req = 1'h1;
		for (int i = 0; i < 8; i++) begin
			{carry_req, second_data_input, first_data_input} = i[2:0];
			tick();
			chk(global_out, data_lut_mask[i]);
			chk(carry_out, carry_lut_mask[i]);
			chk(cascade_out, data_lut_mask[i]);
		end
		fin("arith");
		op_mode = logic_cell_pkg::op_updown;
		{enable_from_first_data_input, clock_enable, second_data_input} = 3'h2;
		{third_data_input, fourth_data_input} = 2'h3;
		tick();
		chk(local_out, 1'h1);
		fourth_data_input = 1'h0;
		tick();
		chk(local_out, 1'h0);
		ctl(logic_cell_pkg::ctl_pre, 1'h1, 1'h0, 1'h1, 1'h1);
		op_mode = logic_cell_pkg::op_clrcnt;
		{cascade_req, fourth_data_input} = 2'h1;
		tick();
		chk(local_out, 1'h0);
		cascade_req = 1'h1;
		global_sel_register = 1'h1;
		tick();
		chk(local_out, 1'h1);
		chk(global_out, 1'h1);
		fin("counters");
		complete_run();
	end
endmodule
bind logic_cell logic_cell_monitor mon_u (.clk, .sys_rst, .op_mode, .ctl_mode, .cascade_enable,
	.cascade_or, .register_packed, .local_sel_register, .enable_from_first_data_input, .chip_reset_enable,
	.chip_reset_presets, .first_data_input, .third_data_input, .fourth_data_input, .cascade_in,
	.clock_enable, .group_control_a_n, .group_control_b_n, .chip_reset_n, .tri_enable,
	.local_out, .carry_out, .cascade_out, .tri_bus_out);
